//--- src/cell_guard_defines.svh
// Timing figures, derived counts and reset values of the cell guard.
// Assumes a 100 MHz system clock and a 10 us slow tick made from it.
`ifndef CELL_GUARD_DEFINES_SVH
`define CELL_GUARD_DEFINES_SVH

// ==========================================================================
// Clock and slow tick
`define CLK_PERIOD_NS    10
`define TICK_PERIOD_NS   10000
`define TICK_CYCLES      ((`TICK_PERIOD_NS + `CLK_PERIOD_NS - 1) / `CLK_PERIOD_NS)

// ==========================================================================
// Delay times in microseconds, typical figures
`define T_CU_US          1000000
`define T_DL_US          115000
`define T_DOC_US         10000
`define T_SHORT_US       360
`define T_COC_US         10000
`define T_DLR_US         2000

// Least times round up to whole ticks.
`define TICKS_OF(us)     ((((us) * 1000) + `TICK_PERIOD_NS - 1) / `TICK_PERIOD_NS)
`define CNT_CU           `TICKS_OF(`T_CU_US)
`define CNT_DL           `TICKS_OF(`T_DL_US)
`define CNT_DOC          `TICKS_OF(`T_DOC_US)
`define CNT_SHORT        `TICKS_OF(`T_SHORT_US)
`define CNT_COC          `TICKS_OF(`T_COC_US)
`define CNT_DLR          `TICKS_OF(`T_DLR_US)

// ==========================================================================
// Reset values
`define SW_RESET         5'h18
`define TICK_CNT_RESET   10'h000
`define TMR_CNT_RESET    17'h00000

`endif

//--- src/cell_guard_pkg.sv
// Types shared by the cell guard, its tick divider and its delay timers.
// Assumes nothing beyond a SystemVerilog compiler.
package cell_guard_pkg;

    typedef logic [16:0] tick_cnt_t;

    typedef enum logic [6:0] {
        ST_NORMAL        = 7'h01,
        ST_OVERCHARGE    = 7'h02,
        ST_OVERDISCHARGE = 7'h04,
        ST_DRAIN_OC      = 7'h08,
        ST_LOAD_SHORT    = 7'h10,
        ST_FILL_OC       = 7'h20,
        ST_SLEEP         = 7'h40
    } guard_state_t;

    // Comparator results, each high while its condition holds.
    typedef struct packed {
        logic cell_above_cu;
        logic cell_below_cl;
        logic cell_below_dl;
        logic cell_above_du;
        logic cell_zero;
        logic sense_ge_doc;
        logic sense_ge_short;
        logic sense_le_coc;
        logic sense_charger;
        logic sense_near_ground;
        logic charger_ov;
        logic charger_ov_clear;
    } compare_t;

    typedef struct packed {
        logic charge_en;
        logic discharge_en;
        logic sense_pullup_en;
        logic sense_pulldown_en;
        logic sleep;
    } switch_t;

    typedef struct packed {
        logic [9:0] cnt;
        logic       tick;
    } tick_state_t;

    typedef struct packed {
        tick_cnt_t cnt;
        logic      done;
    } timer_state_t;

    typedef struct packed {
        compare_t     s1;
        compare_t     s2;
        compare_t     s3;
        compare_t     filt;
        guard_state_t state;
        logic         ov;
        switch_t      sw;
    } guard_regs_t;

endpackage

//--- src/slow_tick.sv
// Divider that makes the slow timer tick as a one-cycle enable.
// Assumes one clock domain and a synchronous reset.
`timescale 1ns/10ps
`default_nettype none
`include "cell_guard_defines.svh"

module slow_tick (
    // Clock and reset
    input  wire logic clock,
    input  wire logic sys_rst,
    // Tick
    output logic      tick
);
    import cell_guard_pkg::*;

    tick_state_t r_r;
    tick_state_t r_nxt;

    always_comb begin
        r_nxt      = r_r;
        r_nxt.tick = 1'b0;
        if (r_r.cnt == 10'(`TICK_CYCLES - 1)) begin
            r_nxt.cnt  = `TICK_CNT_RESET;
            r_nxt.tick = 1'b1;
        end else begin
            r_nxt.cnt = r_r.cnt + 10'h001;
        end
    end

    always_ff @(posedge clock) begin
        if (sys_rst) begin
            r_r <= {`TICK_CNT_RESET, 1'b0};
        end else begin
            r_r <= r_nxt;
        end
    end

    assign tick = r_r.tick;
endmodule // slow_tick
`default_nettype wire

//--- src/qual_timer.sv
// Qualification delay timer counting slow ticks while its condition holds.
// Assumes the condition and tick come from the same clock domain.
`timescale 1ns/10ps
`default_nettype none
`include "cell_guard_defines.svh"

module qual_timer (
    // Clock and reset
    input  wire logic                     clock,
    input  wire logic                     sys_rst,
    // Timing
    input  wire logic                     tick,
    input  wire cell_guard_pkg::tick_cnt_t limit,
    // Condition and result
    input  wire logic                     cond,
    output logic                          done
);
    import cell_guard_pkg::*;

    timer_state_t r_r;
    timer_state_t r_nxt;

    always_comb begin
        r_nxt = r_r;
        if (!cond) begin
            r_nxt.cnt  = `TMR_CNT_RESET;
            r_nxt.done = 1'b0;
        end else if (tick && !r_r.done) begin
            r_nxt.cnt  = r_r.cnt + 17'h00001;
            r_nxt.done = (r_nxt.cnt >= limit);
        end
    end

    always_ff @(posedge clock) begin
        if (sys_rst) begin
            r_r <= {`TMR_CNT_RESET, 1'b0};
        end else begin
            r_r <= r_nxt;
        end
    end

    assign done = r_r.done;
endmodule // qual_timer
`default_nettype wire

//--- src/cell_guard.sv
// Protection state machine of a one-cell battery guard.
// Assumes analog comparators outside the clock domain and a 100 MHz clock.
`timescale 1ns/10ps
`default_nettype none
`include "cell_guard_defines.svh"

module cell_guard #(
    parameter logic                      AUTO_WAKEUP   = 1'b1,
    parameter logic                      ZERO_V_PERMIT = 1'b1,
    parameter cell_guard_pkg::tick_cnt_t CU_TICKS      = 17'(`CNT_CU),
    parameter cell_guard_pkg::tick_cnt_t DL_TICKS      = 17'(`CNT_DL)
) (
    // Clock and reset
    input  wire logic                     clock,
    input  wire logic                     sys_rst,
    // Comparator results from the analog front end
    input  wire cell_guard_pkg::compare_t compare_in,
    // Switch and sense pin controls
    output logic                          charge_en,
    output logic                          discharge_en,
    output logic                          sense_pullup_en,
    output logic                          sense_pulldown_en,
    output logic                          sleep
);
    import cell_guard_pkg::*;

    // ======================================================================
    // State and timer results
    guard_regs_t  r_r;
    guard_regs_t  r_nxt;
    compare_t     f;
    logic         tick;
    logic         cu_done;
    logic         dl_done;
    logic         doc_done;
    logic         short_done;
    logic         coc_done;
    logic         dlr_done;
    logic         in_normal;
    logic         charge_block;
    compare_t     agree;

    assign f         = r_r.filt;
    assign in_normal = (r_r.state == ST_NORMAL);

    // ======================================================================
    // Slow tick and delay timers
    slow_tick u_tick (
        .clock   (clock),
        .sys_rst (sys_rst),
        .tick    (tick)
    );

    // Detection timers only run in normal state, so each restarts fresh.
    qual_timer u_cu (
        .clock   (clock),
        .sys_rst (sys_rst),
        .tick    (tick),
        .limit   (CU_TICKS),
        .cond    (in_normal && f.cell_above_cu),
        .done    (cu_done)
    );

    qual_timer u_dl (
        .clock   (clock),
        .sys_rst (sys_rst),
        .tick    (tick),
        .limit   (DL_TICKS),
        .cond    (in_normal && f.cell_below_dl),
        .done    (dl_done)
    );

    qual_timer u_doc (
        .clock   (clock),
        .sys_rst (sys_rst),
        .tick    (tick),
        .limit   (17'(`CNT_DOC)),
        .cond    (in_normal && f.sense_ge_doc && !f.sense_ge_short),
        .done    (doc_done)
    );

    qual_timer u_short (
        .clock   (clock),
        .sys_rst (sys_rst),
        .tick    (tick),
        .limit   (17'(`CNT_SHORT)),
        .cond    (in_normal && f.sense_ge_short),
        .done    (short_done)
    );

    qual_timer u_coc (
        .clock   (clock),
        .sys_rst (sys_rst),
        .tick    (tick),
        .limit   (17'(`CNT_COC)),
        .cond    (in_normal && f.sense_le_coc),
        .done    (coc_done)
    );

    // The release timer only runs without a charger, at or above release level.
    qual_timer u_dlr (
        .clock   (clock),
        .sys_rst (sys_rst),
        .tick    (tick),
        .limit   (17'(`CNT_DLR)),
        .cond    ((r_r.state == ST_OVERDISCHARGE) && !f.sense_charger
                  && f.cell_above_du),
        .done    (dlr_done)
    );

    // ======================================================================
    // Next state
    always_comb begin
        r_nxt = r_r;

        // Three-stage synchroniser; a change counts when stages two and three agree.
        r_nxt.s1   = compare_in;
        r_nxt.s2   = r_r.s1;
        r_nxt.s3   = r_r.s2;
        agree      = compare_t'(~(r_r.s2 ^ r_r.s3));
        r_nxt.filt = compare_t'((r_r.s3 & agree) | (r_r.filt & ~agree));

        // Charger overvoltage is a plain hysteresis latch with no timer.
        if (f.charger_ov) begin
            r_nxt.ov = 1'b1;
        end else if (f.charger_ov_clear) begin
            r_nxt.ov = 1'b0;
        end

        case (r_r.state)
            ST_NORMAL: begin
                // Short wins, then drain overcurrent, overdischarge, overcharge and fill overcurrent, when several expire together.
                if (short_done) begin
                    r_nxt.state = ST_LOAD_SHORT;
                end else if (doc_done) begin
                    r_nxt.state = ST_DRAIN_OC;
                end else if (dl_done) begin
                    if (AUTO_WAKEUP) begin
                        r_nxt.state = ST_OVERDISCHARGE;
                    end else begin
                        r_nxt.state = ST_SLEEP;
                    end
                end else if (cu_done) begin
                    r_nxt.state = ST_OVERCHARGE;
                end else if (coc_done) begin
                    r_nxt.state = ST_FILL_OC;
                end
            end
            ST_OVERCHARGE: begin
                if (!f.sense_ge_doc && f.cell_below_cl) begin
                    r_nxt.state = ST_NORMAL;
                end else if (f.sense_ge_doc && !f.cell_above_cu) begin
                    r_nxt.state = ST_NORMAL;
                end
            end
            ST_OVERDISCHARGE: begin
                if (f.sense_charger) begin
                    if (!f.cell_below_dl) begin
                        r_nxt.state = ST_NORMAL;
                    end
                end else if (AUTO_WAKEUP && dlr_done) begin
                    r_nxt.state = ST_NORMAL;
                end
            end
            ST_DRAIN_OC, ST_LOAD_SHORT: begin
                if (f.sense_near_ground) begin
                    r_nxt.state = ST_NORMAL;
                end
            end
            ST_FILL_OC: begin
                // Charger removal lets the sense pin rise out of the fill band.
                if (!f.sense_le_coc) begin
                    r_nxt.state = ST_NORMAL;
                end
            end
            ST_SLEEP: begin
                // Waking goes through overdischarge so the cell is checked first.
                if (f.sense_charger) begin
                    r_nxt.state = ST_OVERDISCHARGE;
                end
            end
            default: begin
                r_nxt.state = ST_NORMAL;
            end
        endcase

        // Outputs follow the next state so they line up with the state register.
        charge_block = r_nxt.ov || (!ZERO_V_PERMIT && f.cell_zero);
        r_nxt.sw.charge_en = !charge_block
                             && (r_nxt.state != ST_OVERCHARGE)
                             && (r_nxt.state != ST_FILL_OC);
        r_nxt.sw.discharge_en = (r_nxt.state == ST_NORMAL)
                                || (r_nxt.state == ST_OVERCHARGE)
                                || (r_nxt.state == ST_FILL_OC);
        r_nxt.sw.sense_pullup_en = (r_nxt.state == ST_OVERDISCHARGE)
                                   || (r_nxt.state == ST_SLEEP);
        r_nxt.sw.sense_pulldown_en = (r_nxt.state == ST_DRAIN_OC)
                                     || (r_nxt.state == ST_LOAD_SHORT);
        r_nxt.sw.sleep = (r_nxt.state == ST_SLEEP);
    end

    // ======================================================================
    // State register
    always_ff @(posedge clock) begin
        if (sys_rst) begin
            r_r.s1    <= '0;
            r_r.s2    <= '0;
            r_r.s3    <= '0;
            r_r.filt  <= '0;
            r_r.state <= ST_NORMAL;
            r_r.ov    <= 1'b0;
            r_r.sw    <= `SW_RESET;
        end else begin
            r_r <= r_nxt;
        end
    end

    assign charge_en         = r_r.sw.charge_en;
    assign discharge_en      = r_r.sw.discharge_en;
    assign sense_pullup_en   = r_r.sw.sense_pullup_en;
    assign sense_pulldown_en = r_r.sw.sense_pulldown_en;
    assign sleep             = r_r.sw.sleep;

    // ======================================================================
    // Assertions
    default clocking cb @(posedge clock); endclocking
    default disable iff (sys_rst);

    sequence s_leave_od;
        (r_r.state == ST_OVERDISCHARGE) ##1 (r_r.state == ST_NORMAL);
    endsequence

    sequence s_leave_sleep;
        (r_r.state == ST_SLEEP) ##1 (r_r.state != ST_SLEEP);
    endsequence

    sequence s_enter_oc;
        (r_r.state == ST_NORMAL) ##1 (r_r.state == ST_OVERCHARGE);
    endsequence

    a_normal_both_on: assert property (
        (in_normal && !r_r.ov && ZERO_V_PERMIT) |-> (charge_en && discharge_en))
        else $error("normal state without both switches on");

    a_quiet_pulls: assert property (
        (in_normal || r_r.state == ST_OVERCHARGE)
            |-> (!sense_pullup_en && !sense_pulldown_en))
        else $error("sense pulls active in normal or overcharge");

    a_overcharge_entry: assert property (
        s_enter_oc |-> ($past(cu_done) && !charge_en && discharge_en))
        else $error("overcharge entered without its delay");

    a_od_pullup: assert property (
        (r_r.state == ST_OVERDISCHARGE) |-> (sense_pullup_en && !sense_pulldown_en
                                             && !discharge_en))
        else $error("overdischarge pulls or switch wrong");

    a_od_release: assert property (
        s_leave_od |-> ($past(f.sense_charger) || $past(dlr_done)))
        else $error("overdischarge left without charger or release delay");

    a_sleep_wake: assert property (
        s_leave_sleep |-> ($past(f.sense_charger) && r_r.state == ST_OVERDISCHARGE))
        else $error("sleep left without charger");

    a_short_entry: assert property (
        (in_normal && short_done) |=> (r_r.state == ST_LOAD_SHORT && !discharge_en
                                       && sense_pulldown_en))
        else $error("short delay expired without cutting discharge");

    a_short_release: assert property (
        (r_r.state == ST_LOAD_SHORT && f.sense_near_ground) |=> in_normal)
        else $error("short state held with sense near ground");

    a_charger_ov: assert property (
        (f.charger_ov) |=> (r_r.ov && !charge_en))
        else $error("charger overvoltage did not cut charge at once");

    a_ov_release: assert property (
        (r_r.ov && !f.charger_ov && f.charger_ov_clear) |=> !r_r.ov)
        else $error("charger overvoltage not released");

    a_drain_entry: assert property (
        (in_normal && doc_done && !short_done) |=> (r_r.state == ST_DRAIN_OC
                                                    && !discharge_en && sense_pulldown_en))
        else $error("drain overcurrent delay expired without cutting discharge");

    a_fill_entry: assert property (
        (in_normal && coc_done && !short_done && !doc_done && !dl_done && !cu_done)
            |=> (r_r.state == ST_FILL_OC && !charge_en))
        else $error("fill overcurrent delay expired without cutting charge");

    // The default disable would mask the very reset this property watches.
    a_reset_state: assert property (
        @(posedge clock) disable iff (1'b0)
        sys_rst |=> (in_normal && !dl_done && !cu_done))
        else $error("reset did not restore normal state");

endmodule // cell_guard
`default_nettype wire

//--- sim/comparator_model.sv
// Model of the analog comparator front end that turns voltages into levels.
// Assumes the bench gives cell and sense voltages in millivolts.
`timescale 1ns/10ps
`default_nettype none

module comparator_model #(
    parameter int CU_MV    = 4200,
    parameter int CL_MV    = 4000,
    parameter int DL_MV    = 2700,
    parameter int DU_MV    = 2800,
    parameter int ZERO_MV  = 300,
    parameter int DOC_MV   = 100,
    parameter int SHORT_MV = 200,
    parameter int COC_MV   = -50,
    parameter int CHG_MV   = -700,
    parameter int NEAR_MV  = 20,
    parameter int OV_MV    = 8000,
    parameter int OVR_MV   = 7300
) (
    // Analog levels
    input  var int                       cell_mv,
    input  var int                       sense_mv,
    // Comparator results
    output var cell_guard_pkg::compare_t cmp_out
);
    import cell_guard_pkg::*;

    // The charger sees the cell plus the drop below ground on the sense pin.
    int chg_mv;

    always_comb begin
        chg_mv                    = cell_mv - sense_mv;
        cmp_out.cell_above_cu     = cell_mv > CU_MV;
        cmp_out.cell_below_cl     = cell_mv < CL_MV;
        cmp_out.cell_below_dl     = cell_mv < DL_MV;
        cmp_out.cell_above_du     = cell_mv >= DU_MV;
        cmp_out.cell_zero         = cell_mv < ZERO_MV;
        cmp_out.sense_ge_doc      = sense_mv >= DOC_MV;
        cmp_out.sense_ge_short    = sense_mv >= SHORT_MV;
        cmp_out.sense_le_coc      = sense_mv <= COC_MV;
        cmp_out.sense_charger     = sense_mv < CHG_MV;
        cmp_out.sense_near_ground = sense_mv < NEAR_MV;
        cmp_out.charger_ov        = chg_mv > OV_MV;
        cmp_out.charger_ov_clear  = chg_mv < OVR_MV;
    end

endmodule // comparator_model

`default_nettype wire

//--- sim/cell_guard_bench.sv
// Self-checking bench of the cell guard with a comparator model in front.
// Assumes the guard's package and shortened overcharge and overdischarge counts.
`timescale 1ns/10ps
`default_nettype none

module cell_guard_bench;
    import cell_guard_pkg::*;

    // ==========================================================================
    // Settings and expected switch patterns
    localparam int      TICK    = 1000;
    localparam int      CU_T    = 12;
    localparam int      DL_T    = 10;
    localparam int      SHORT_T = 36;
    localparam switch_t NORM_SW = 5'h18;
    localparam switch_t OC_SW   = 5'h08;
    localparam switch_t OD_SW   = 5'h14;
    localparam switch_t DOC_SW  = 5'h12;

    logic     clock;
    logic     sys_rst;
    int       cell_mv;
    int       sense_mv;
    int       seed;
    int       bad_count;
    int       n_compared;
    compare_t cmp;
    switch_t  seen;
    switch_t  last_sw;
    switch_t  notes[$];
    logic     charge_en;
    logic     discharge_en;
    logic     sense_pullup_en;
    logic     sense_pulldown_en;
    logic     sleep;

    comparator_model comparator_model_i (
        .cell_mv  (cell_mv),
        .sense_mv (sense_mv),
        .cmp_out  (cmp)
    );

    cell_guard #(
        .CU_TICKS (17'(CU_T)),
        .DL_TICKS (17'(DL_T))
    ) cell_guard_i (
        .clock             (clock),
        .sys_rst           (sys_rst),
        .compare_in        (cmp),
        .charge_en         (charge_en),
        .discharge_en      (discharge_en),
        .sense_pullup_en   (sense_pullup_en),
        .sense_pulldown_en (sense_pulldown_en),
        .sleep             (sleep)
    );

    assign seen = {charge_en, discharge_en, sense_pullup_en, sense_pulldown_en, sleep};

    // ==========================================================================
    // Shared tasks
    task automatic check(input switch_t got, input switch_t exp);
        n_compared++;
        if (got !== exp) begin
            bad_count++;
            $display("[FAIL] %0t switches %b expected %b", $time, got, exp);
        end
    endtask

    task automatic stop_test;
        $display("Compared %0d, mismatches %0d", n_compared, bad_count);
        if (bad_count == 0 && n_compared > 0) begin
            $display("DONE - PASS");
        end else begin
            $display("DONE - FAIL");
        end
        $finish;
    endtask

    task automatic drive(input int c, input int s);
        @(posedge clock);
        cell_mv  <= c;
        sense_mv <= s;
    endtask

    // Notes a change that may show only after lo cycles and must within hi more.
    task automatic expect_sw(input switch_t exp, input int lo, input int hi);
        int n;
        repeat (lo) @(posedge clock);
        notes.push_back(exp);
        n = 0;
        while (notes.size() != 0 && n < hi) begin
            @(posedge clock);
            #2;
            n++;
        end
        if (notes.size() != 0) begin
            notes.delete();
            bad_count++;
            $display("[FAIL] %0t expected switch change missing", $time);
        end
    endtask

    // ==========================================================================
    // Clock, watchdog and output watcher
    initial begin
        clock = 1'b0;
        forever #5 clock = ~clock;
    end

    initial begin
        repeat (99000) @(posedge clock);
        bad_count++;
        $display("[FAIL] %0t run did not finish in time", $time);
        stop_test();
    end

    // Any change with no note pending is compared with the old value, so it fails.
    initial begin
        last_sw = NORM_SW;
        forever begin
            @(posedge clock);
            #1;
            if (sys_rst === 1'b0 && seen !== last_sw) begin
                check(seen, (notes.size() == 0) ? last_sw : notes.pop_front());
            end
            last_sw = seen;
        end
    end

    // ==========================================================================
    // Main sequence
    initial begin
        seed       = 32'h36cb;
        bad_count  = 0;
        n_compared = 0;
        sys_rst    = 1'b1;
        cell_mv    = 3600;
        sense_mv   = 0;
        repeat (20) @(posedge clock);
        sys_rst <= 1'b0;
        @(posedge clock);
        #2;
        check(seen, NORM_SW);
        // Random levels inside the normal band must never move a switch.
        repeat (60) begin
            drive(3000 + (($random(seed) & 32'h7FFFFFFF) % 900), $random(seed) % 40);
        end
        drive(3600, 300);
        expect_sw(DOC_SW, (SHORT_T - 1) * TICK, 2 * TICK + 20);
        drive(3600, 0);
        expect_sw(NORM_SW, 0, 20);
        for (int i = 0; i < 2; i++) begin
            drive(4300, 0);
            expect_sw(OC_SW, (CU_T - 1) * TICK, 2 * TICK + 20);
            drive(4100, i * 150);
            if (i == 0) begin
                repeat (100) @(posedge clock);
                drive(3900, 0);
            end
            expect_sw(NORM_SW, 0, 20);
            drive(3600, 0);
        end
        // A lapse before the count is reached must start the count again.
        repeat (2) begin
            drive(2500, 0);
            repeat ((DL_T - 3) * TICK) @(posedge clock);
            drive(3600, 0);
            repeat (2 * TICK) @(posedge clock);
        end
        drive(2500, 0);
        expect_sw(OD_SW, (DL_T - 1) * TICK, 2 * TICK + 20);
        drive(2750, 0);
        repeat (100) @(posedge clock);
        drive(2500, -1000);
        repeat (100) @(posedge clock);
        drive(2750, -1000);
        expect_sw(NORM_SW, 0, 20);
        drive(3600, 0);
        drive(3600, -5000);
        expect_sw(OC_SW, 0, 8);
        drive(3600, -4000);
        repeat (20) @(posedge clock);
        drive(3600, 0);
        expect_sw(NORM_SW, 0, 8);
        repeat (20) @(posedge clock);
        stop_test();
    end

endmodule // cell_guard_bench

`default_nettype wire
